// file: logic/bsx_exec.sv
`default_nettype none
`include "bsx_cfg.svh"
module bsx_exec
    import bsx_pkg::*;
(
    // clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rst,
    // instruction issue
    input  wire logic                       ins_valid,
    input  wire bsx_instr_t                 ins,
    output logic                            ins_ready,
    // data memory read port (combinational read)
    output logic [`BSX_DADDR_W-1:0]         dmem_raddr,
    input  wire logic [`BSX_DATA_W-1:0]     dmem_rdata,
    // data memory write port
    output bsx_dwr_t                        dmem_wr,
    // program memory read port (combinational read)
    input  wire logic [`BSX_PADDR_W-1:0]    pc,
    input  wire logic [`BSX_DATA_W-1:0]     table_address_pointer,
    output logic [`BSX_PADDR_W-1:0]         pmem_addr,
    input  wire logic [`BSX_WORD_W-1:0]     pmem_rdata,
    // core state
    output logic [`BSX_DATA_W-1:0]          accumulator,
    output logic                            zero_flag,
    output logic [`BSX_DATA_W-1:0]          table_high_byte_reg,
    output logic                            skip_dummy
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        BSX_ST_RUN   = 1'b0,
        BSX_ST_DUMMY = 1'b1
    } bsx_state_t;

    bsx_state_t                 st_r, st_nxt;
    logic [`BSX_DATA_W-1:0]     acc_r, acc_nxt;
    logic                       z_r, z_nxt;
    logic [`BSX_DATA_W-1:0]     thb_r, thb_nxt;
    bsx_dwr_t                   wr_r, wr_nxt;
    logic [`BSX_DATA_W-1:0]     xor_b;
    logic [`BSX_DATA_W-1:0]     xor_res;
    logic                       xor_zero;
    logic                       take;

    // a new instruction is refused while the dummy cycle runs
    assign ins_ready  = (st_r == BSX_ST_RUN);
    assign take       = ins_valid && ins_ready;
    assign dmem_raddr = ins.addr;
    assign xor_b      = (ins.op == BSX_OP_XORI) ? ins.imm : dmem_rdata;

    // ------------------------------------------------------------
    // table fetch address: page bits from pc or fixed last page
    // ------------------------------------------------------------
    always_comb
    begin
        if (ins.op == BSX_OP_TRDL)
            pmem_addr = {`BSX_LAST_PAGE, table_address_pointer};
        else
            pmem_addr = {pc[`BSX_PADDR_W-1 -: `BSX_PAGE_W],
                         table_address_pointer};
    end

    bsx_xor_unit u_xor (
        .opa  (acc_r),
        .opb  (xor_b),
        .res  (xor_res),
        .zero (xor_zero)
    );

    // ------------------------------------------------------------
    // next-state decode
    // ------------------------------------------------------------
    // flags hold by default; only xor ops touch the zero flag
    always_comb
    begin
        st_nxt   = BSX_ST_RUN;
        acc_nxt  = acc_r;
        z_nxt    = z_r;
        thb_nxt  = thb_r;
        wr_nxt   = '0;
        if (take)
        begin
            case (ins.op)
                BSX_OP_SKIPZ:
                begin
                    if (!dmem_rdata[ins.bit_sel])
                        st_nxt = BSX_ST_DUMMY;
                end
                BSX_OP_TRDC, BSX_OP_TRDL:
                begin
                    wr_nxt   = '{1'b1, ins.addr,
                                 pmem_rdata[`BSX_DATA_W-1:0]};
                    thb_nxt  = pmem_rdata[`BSX_WORD_W-1:`BSX_DATA_W];
                end
                BSX_OP_XORA, BSX_OP_XORI:
                begin
                    acc_nxt = xor_res;
                    z_nxt   = xor_zero;
                end
                BSX_OP_XORW:
                begin
                    wr_nxt = '{1'b1, ins.addr, xor_res};
                    z_nxt  = xor_zero;
                end
                default:
                begin
                    st_nxt = BSX_ST_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_r   <= BSX_ST_RUN;
            acc_r  <= `BSX_ACC_RST;
            z_r    <= `BSX_ZERO_RST;
            thb_r  <= `BSX_THB_RST;
            wr_r   <= '0;
        end
        else
        begin
            st_r   <= st_nxt;
            acc_r  <= acc_nxt;
            z_r    <= z_nxt;
            thb_r  <= thb_nxt;
            wr_r   <= wr_nxt;
        end
    end

    assign accumulator         = acc_r;
    assign zero_flag           = z_r;
    assign table_high_byte_reg = thb_r;
    assign dmem_wr             = wr_r;
    assign skip_dummy          = (st_r == BSX_ST_DUMMY);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_skip_taken;
        take && ins.op == BSX_OP_SKIPZ && !dmem_rdata[ins.bit_sel];
    endsequence

    sequence s_trdl_taken;
        take && ins.op == BSX_OP_TRDL;
    endsequence

    // any of the three xor forms, all of which own the zero flag
    sequence s_xor_taken;
        take && ins.op inside {BSX_OP_XORA, BSX_OP_XORW, BSX_OP_XORI};
    endsequence

    chk_skip_dummy: assert property (@(posedge mclk) disable iff (rst)
        s_skip_taken |=> skip_dummy ##1 !skip_dummy)
        else $error("skip did not insert one dummy cycle");
    chk_skip_noflag: assert property (@(posedge mclk) disable iff (rst)
        take && ins.op == BSX_OP_SKIPZ |=> $stable(z_r) && !dmem_wr.we)
        else $error("skip changed flag or memory");
    chk_trdc_low: assert property (@(posedge mclk) disable iff (rst)
        take && ins.op == BSX_OP_TRDC |=> dmem_wr.we &&
        dmem_wr.wdata == $past(pmem_rdata[7:0]) && $stable(z_r))
        else $error("current page low byte not written");
    chk_trdc_high: assert property (@(posedge mclk) disable iff (rst)
        take && ins.op == BSX_OP_TRDC |=>
        table_high_byte_reg == $past(pmem_rdata[15:8]))
        else $error("table high byte not loaded");
    chk_trdl_page: assert property (@(posedge mclk) disable iff (rst)
        take && ins.op == BSX_OP_TRDL |->
        pmem_addr[`BSX_PADDR_W-1 -: `BSX_PAGE_W] == `BSX_LAST_PAGE
        ##1 table_high_byte_reg == $past(pmem_rdata[15:8]))
        else $error("last page read wrong");
    chk_xora_acc: assert property (@(posedge mclk) disable iff (rst)
        take && ins.op == BSX_OP_XORA |=>
        acc_r == ($past(acc_r) ^ $past(dmem_rdata)) && !dmem_wr.we)
        else $error("xor to accumulator wrong");
    chk_xor_mem_wr: assert property (@(posedge mclk) disable iff (rst)
        take && ins.op == BSX_OP_XORW |=> dmem_wr.we &&
        dmem_wr.wdata == ($past(acc_r) ^ $past(dmem_rdata)) && $stable(acc_r))
        else $error("xor into memory wrong");
    chk_xori_acc: assert property (@(posedge mclk) disable iff (rst)
        take && ins.op == BSX_OP_XORI |=>
        acc_r == ($past(acc_r) ^ $past(ins.imm)))
        else $error("xor immediate wrong");
    chk_zero_flag: assert property (@(posedge mclk) disable iff (rst)
        s_xor_taken |=>
        z_r == ($past(xor_res) == 8'h00))
        else $error("zero flag wrong after xor");

    // ------------------------------------------------------------
    // further checks: last-page low byte, refusal, untouched state
    // ------------------------------------------------------------
    // last page low byte goes to memory, flags stay put
    chk_trdl_low: assert property (@(posedge mclk) disable iff (rst)
        s_trdl_taken |=> dmem_wr.we &&
        dmem_wr.wdata == $past(pmem_rdata[7:0]) && $stable(z_r))
        else $error("last page low byte not written");

    // the word offered during the dummy cycle must not execute
    chk_dummy_refuse: assert property (@(posedge mclk) disable iff (rst)
        skip_dummy |-> !ins_ready ##1 $stable(acc_r) && !dmem_wr.we)
        else $error("instruction taken in dummy cycle");

    // a skip whose bit is set runs on with no dummy cycle
    chk_skip_pass: assert property (@(posedge mclk) disable iff (rst)
        take && ins.op == BSX_OP_SKIPZ && dmem_rdata[ins.bit_sel] |=>
        !skip_dummy)
        else $error("skip with bit set stalled");

    // xor never touches the table high byte
    chk_xor_keeps_thb: assert property (@(posedge mclk) disable iff (rst)
        s_xor_taken |=> $stable(thb_r))
        else $error("xor changed table high byte");

    // table reads leave the accumulator alone
    chk_table_acc: assert property (@(posedge mclk) disable iff (rst)
        take && ins.op inside {BSX_OP_TRDC, BSX_OP_TRDL} |=> $stable(acc_r))
        else $error("table read changed accumulator");
endmodule // bsx_exec
`default_nettype wire

// file: logic/bsx_cfg.svh
// Overview of operation
// - clear memory bit skips next instruction via dummy cycle; flags kept.
// - current-page table read writes word low byte to memory; flags kept.
// - current-page table read loads word high byte into table high byte.
// - last-page table read: low byte to memory, high byte to register.
// - accumulator xor memory goes to accumulator; only zero flag updated.
// - accumulator xor memory goes back to memory; only zero flag updated.
// - accumulator xor immediate into accumulator; only zero flag updated.
`ifndef BSX_CFG_SVH
`define BSX_CFG_SVH
`define BSX_DATA_W      8
`define BSX_DADDR_W     7
`define BSX_PADDR_W     10
`define BSX_PAGE_W      2
`define BSX_WORD_W      16
`define BSX_ACC_RST     8'h00
`define BSX_ZERO_RST    1'b0
`define BSX_THB_RST     8'h00
`define BSX_LAST_PAGE   2'h3
`endif

// file: logic/bsx_pkg.sv
`default_nettype none
`include "bsx_cfg.svh"
package bsx_pkg;
    // ------------------------------------------------------------
    // operation codes and carried instruction fields
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BSX_OP_NONE   = 3'b000,
        BSX_OP_SKIPZ  = 3'b001,
        BSX_OP_TRDC   = 3'b010,
        BSX_OP_TRDL   = 3'b011,
        BSX_OP_XORA   = 3'b100,
        BSX_OP_XORW   = 3'b101,
        BSX_OP_XORI   = 3'b110
    } bsx_op_t;

    typedef struct packed {
        bsx_op_t                    op;
        logic [`BSX_DADDR_W-1:0]    addr;
        logic [2:0]                 bit_sel;
        logic [`BSX_DATA_W-1:0]     imm;
    } bsx_instr_t;

    typedef struct packed {
        logic                       we;
        logic [`BSX_DADDR_W-1:0]    addr;
        logic [`BSX_DATA_W-1:0]     wdata;
    } bsx_dwr_t;
endpackage
`default_nettype wire

// file: logic/bsx_xor_unit.sv
`default_nettype none
`include "bsx_cfg.svh"
module bsx_xor_unit
    import bsx_pkg::*;
(
    // operands
    input  wire logic [`BSX_DATA_W-1:0] opa,
    input  wire logic [`BSX_DATA_W-1:0] opb,
    // result
    output logic [`BSX_DATA_W-1:0]      res,
    output logic                        zero
);
    // ------------------------------------------------------------
    // bitwise xor, one generate lane per bit
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `BSX_DATA_W; g++)
        begin : g_lane
            assign res[g] = opa[g] ^ opb[g];
        end
    endgenerate

    // zero flag from the full byte
    assign zero = (res == '0);
endmodule // bsx_xor_unit
`default_nettype wire

// file: tb/bsx_mem_model.sv
`default_nettype none
`include "bsx_cfg.svh"
module bsx_mem_model
    import bsx_pkg::*;
(
    // clock
    input  wire logic                       mclk,
    // data memory side
    input  wire logic [`BSX_DADDR_W-1:0]    dmem_raddr,
    output logic [`BSX_DATA_W-1:0]          dmem_rdata,
    input  wire bsx_dwr_t                   dmem_wr,
    // program memory side
    input  wire logic [`BSX_PADDR_W-1:0]    pmem_addr,
    output logic [`BSX_WORD_W-1:0]          pmem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // data memory array
    // ------------------------------------------------------------
    logic [`BSX_DATA_W-1:0] mem [0:127];
    // scattered start pattern so every byte differs from its neighbours
    initial
    begin
        for (int i = 0; i < 128; i++)
            mem[i] = 8'(i * 37) ^ 8'h11;
    end
    // write lands on the edge that sees the one-cycle strobe
    always @(posedge mclk)
    begin
        if (dmem_wr.we === 1'b1)
            mem[dmem_wr.addr] <= dmem_wr.wdata;
    end
    assign dmem_rdata = mem[dmem_raddr];
    // page bits sit in the high byte so a wrong page shows up at once
    assign pmem_rdata = {6'h2a, pmem_addr[9:8], pmem_addr[7:0] ^ 8'h3c};
endmodule // bsx_mem_model
`default_nettype wire

// file: tb/tb.sv
`default_nettype none
`include "bsx_cfg.svh"
module tb
    import bsx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    mclk, rst, ins_valid, ins_ready;
    logic                    zero_flag, skip_dummy;
    bsx_instr_t              ins;
    bsx_dwr_t                dmem_wr;
    logic [`BSX_DADDR_W-1:0] dmem_raddr;
    logic [7:0]              dmem_rdata, tap, accumulator, thb, a0, m;
    logic                    z0;
    logic [9:0]              pc, pmem_addr;
    logic [15:0]             pmem_rdata;
    int                      n_mismatch, check_count, cycles;
    // ------------------------------------------------------------
    // clock, timeout, design and memory partner
    // ------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // a hang shows up as a mismatch rather than a silent stall
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    bsx_exec u_dut (.mclk(mclk), .rst(rst), .ins_valid(ins_valid),
        .ins(ins), .ins_ready(ins_ready), .dmem_raddr(dmem_raddr),
        .dmem_rdata(dmem_rdata), .dmem_wr(dmem_wr), .pc(pc),
        .table_address_pointer(tap), .pmem_addr(pmem_addr),
        .pmem_rdata(pmem_rdata), .accumulator(accumulator),
        .zero_flag(zero_flag), .table_high_byte_reg(thb),
        .skip_dummy(skip_dummy));
    bsx_mem_model u_mem (.mclk(mclk), .dmem_raddr(dmem_raddr),
        .dmem_rdata(dmem_rdata), .dmem_wr(dmem_wr),
        .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic bsx_instr_t mk(bsx_op_t op, logic [6:0] a,
                                      logic [2:0] b, logic [7:0] im);
        mk = '{op: op, addr: a, bit_sel: b, imm: im};
    endfunction
    // offer one instruction and return just after the edge that takes it
    task automatic exec(input bsx_instr_t i);
        int k;
        @(posedge mclk);
        ins       <= i;
        ins_valid <= 1'b1;
        k = 0;
        // judge ready between edges, where it has settled
        @(negedge mclk);
        while (ins_ready !== 1'b1 && k < 4)
        begin
            @(negedge mclk);
            k++;
        end
        if (k == 4)
            n_mismatch++;
        @(posedge mclk);
        ins_valid <= 1'b0;
        #1;
    endtask
    task automatic stop_test();
        if (n_mismatch == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_xor_imm();
        exec(mk(BSX_OP_XORI, 7'h00, 3'h0, 8'h5a));
        chk("acc", accumulator, 16'h005a);
        chk("zero", zero_flag, 16'h0000);
        exec(mk(BSX_OP_XORI, 7'h00, 3'h0, 8'h5a));
        chk("acc", accumulator, 16'h0000);
        chk("zero", zero_flag, 16'h0001);
    endtask
    task automatic t_xor_acc();
        m = u_mem.mem[5];
        exec(mk(BSX_OP_XORA, 7'h05, 3'h0, 8'h00));
        chk("acc", accumulator, {8'h00, m});
        chk("zero", zero_flag, {15'h0, m == 8'h00});
        chk("we", dmem_wr.we, 16'h0000);
        exec(mk(BSX_OP_XORA, 7'h05, 3'h0, 8'h00));
        chk("acc", accumulator, 16'h0000);
        chk("zero", zero_flag, 16'h0001);
    endtask
    task automatic t_xor_mem();
        exec(mk(BSX_OP_XORI, 7'h00, 3'h0, 8'h0f));
        m = u_mem.mem[9];
        exec(mk(BSX_OP_XORW, 7'h09, 3'h0, 8'h00));
        chk("wr", dmem_wr, {1'b1, 7'h09, m ^ 8'h0f});
        chk("acc", accumulator, 16'h000f);
        chk("zero", zero_flag, {15'h0, m == 8'h0f});
    endtask
    // same path for both pages; only the page of the fetch differs
    task automatic t_table(input bsx_op_t op, input logic [1:0] pg);
        @(posedge mclk);
        pc  <= 10'h1a5;
        tap <= 8'h40;
        z0 = zero_flag;
        exec(mk(op, 7'h14, 3'h0, 8'h00));
        chk("wr", dmem_wr, {1'b1, 7'h14, 8'h7c});
        chk("thb", thb, {8'h00, 6'h2a, pg});
        chk("zero", zero_flag, {15'h0, z0});
    endtask
    // byte 0 holds 8'h11: bit 1 clear, bit 0 set
    task automatic t_skip();
        a0 = accumulator;
        z0 = zero_flag;
        @(posedge mclk);
        ins       <= mk(BSX_OP_SKIPZ, 7'h00, 3'h1, 8'h00);
        ins_valid <= 1'b1;
        @(posedge mclk);
        ins <= mk(BSX_OP_XORI, 7'h00, 3'h0, 8'hff);
        #1;
        chk("skip", skip_dummy, 16'h0001);
        chk("ready", ins_ready, 16'h0000);
        @(posedge mclk);
        ins_valid <= 1'b0;
        #1;
        chk("acc", accumulator, {8'h00, a0});
        chk("zero", zero_flag, {15'h0, z0});
        chk("skip", skip_dummy, 16'h0000);
        exec(mk(BSX_OP_SKIPZ, 7'h00, 3'h0, 8'h00));
        chk("skip", skip_dummy, 16'h0000);
        chk("ready", ins_ready, 16'h0001);
    endtask
    // mid-run reset must clear state left by earlier ops
    task automatic t_reset();
        exec(mk(BSX_OP_XORI, 7'h00, 3'h0, 8'h81));
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk("acc", accumulator, 16'h0000);
        chk("thb", thb, 16'h0000);
        chk("zero", zero_flag, 16'h0000);
        chk("skip", skip_dummy, 16'h0000);
        exec(mk(BSX_OP_XORI, 7'h00, 3'h0, 8'h81));
        chk("acc", accumulator, 16'h0081);
        chk("zero", zero_flag, 16'h0000);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        ins_valid = 1'b0;
        ins = '0;
        pc = '0;
        tap = '0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk("acc", accumulator, 16'h0000);
        chk("zero", zero_flag, 16'h0000);
        chk("thb", thb, 16'h0000);
        chk("skip", skip_dummy, 16'h0000);
        t_xor_imm();
        t_xor_acc();
        t_xor_mem();
        t_table(BSX_OP_TRDC, 2'h1);
        t_table(BSX_OP_TRDL, `BSX_LAST_PAGE);
        t_skip();
        t_reset();
        stop_test();
    end
endmodule // tb
`default_nettype wire
